// >>> tb/ccs_host_model.sv
/*
  Host model: takes reply bytes from the unit, stalling on request.
  Assumes the bench offers commands itself and holds clr while a query is offered.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_host_model (
  // clock
  input wire logic clk,
  // reply side
  input wire logic reply_valid,
  input wire logic [7:0] reply_data,
  output logic reply_ready,
  // bench side
  input wire logic slow,
  input wire logic clr,
  output logic [127:0] acc,
  output logic [7:0] n
);
  initial reply_ready = 1'b0;
  always @(negedge clk) reply_ready <= slow ? !reply_ready : 1'b1;
  // keeps reading every byte, line feed included, until clr empties the store
  always @(posedge clk) begin
    if (clr) begin
      acc <= '0;
      n <= 8'h00;
    end else if (reply_valid && reply_ready) begin
      acc <= {acc[119:0], reply_data};
      n <= n + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> tb/common_command_status_unit_tb.sv
/*
  Bench for the common command unit: a table of command rows, then hand cases.
  Assumes the host model and the default design parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module common_command_status_unit_tb
  import ccs_pkg::*;
;
  typedef struct packed {
    logic [3:0] c;
    logic [7:0] a;
    logic [127:0] e;
  } ccs_row_s;
  logic clk, sys_rst, cmd_valid, cmd_ready, reply_valid, reply_ready, exec_error, device_error;
  logic query_error, ops_busy, chan_load, module_present, trim_supported, rl_switch_fitted;
  logic local_switch_pin, ren_pin, event_summary, status_clear, remote_permit, slow, clr;
  logic [3:0] cmd_code;
  logic [1:0] module_type;
  logic [7:0] cmd_arg, reply_data, chan_value, ctrl_rev, module_rev, stb_other, n;
  logic [127:0] acc;
  int miscompares = 0;
  int total_checks = 0;
  // no reply expected where e is zero
  ccs_row_s rows[16] = '{
    '{CMD_ESE_Q, 8'h00, "0\n"}, '{CMD_ESE, 8'h3c, '0}, '{CMD_ESE_Q, 8'h00, "60\n"},
    '{CMD_UNKNOWN, 8'h00, '0}, '{CMD_ESR_Q, 8'h00, "160\n"}, '{CMD_ESR_Q, 8'h00, "0\n"},
    '{CMD_IDN_Q, 8'h00, "MFGX,PWM2,1,3-4\n"}, '{CMD_OPT_Q, 8'h00, "TRM,RLS\n"},
    '{CMD_STB_Q, 8'h00, "65\n"}, '{CMD_ESE, 8'hff, '0}, '{4'hf, 8'h00, '0},
    '{CMD_STB_Q, 8'h00, "97\n"}, '{CMD_STB_Q, 8'h00, "97\n"}, '{CMD_CLS, 8'h00, '0},
    '{CMD_ESE_Q, 8'h00, "255\n"}, '{CMD_ESR_Q, 8'h00, "0\n"}
  };

  ccs_common_unit uut (.*);
  ccs_host_model host (.*);

  task automatic chk(input string nm, input logic [127:0] g, input logic [127:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [7:0] a);
    @(negedge clk);
    {cmd_valid, clr, cmd_code, cmd_arg} = {2'b11, c, a};
    do @(posedge clk); while (cmd_ready !== 1'b1);
  endtask

  task automatic rd(input logic [127:0] e);
    @(negedge clk);
    {cmd_valid, clr} = 2'b00;
    for (int i = 0; i < 300 && !(acc[7:0] === 8'h0a && n > 0); i++) @(negedge clk);
    chk("reply", acc, e);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    miscompares++;
    end_sim;
  end

  initial begin
    {sys_rst, cmd_valid, clr, cmd_code, cmd_arg, slow, ops_busy, chan_load, chan_value} = {3'b101, 12'h000, 11'h000};
    {exec_error, device_error, query_error, module_present, module_type} = 6'b000110;
    {ctrl_rev, module_rev, stb_other} = 24'h030461;
    {trim_supported, rl_switch_fitted, local_switch_pin, ren_pin} = 4'b1101;
    repeat (10) @(negedge clk);
    chk("reset outputs", {cmd_ready, reply_valid, event_summary, status_clear}, 4'h0);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      cmd(rows[i].c, rows[i].a);
      if (rows[i].e !== '0) rd(rows[i].e);
    end
    cmd(CMD_CLS, 8'h00);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < 3 && status_clear !== 1'b1; i++) @(negedge clk);
    chk("status_clear", status_clear, 1'b1);
    ops_busy = 1'b1;
    cmd(CMD_OPC, 8'h00);
    cmd(CMD_ESR_Q, 8'h00);
    rd("0\n");
    ops_busy = 1'b0;
    repeat (3) @(negedge clk);
    cmd(CMD_ESR_Q, 8'h00);
    rd("1\n");
    ops_busy = 1'b1;
    cmd(CMD_OPC_Q, 8'h00);
    @(negedge clk);
    {cmd_valid, clr} = 2'b00;
    repeat (20) @(negedge clk);
    chk("held reply", {n, cmd_ready}, 9'h000);
    ops_busy = 1'b0;
    rd("1\n");
    for (int i = 0; i < 3; i++) begin
      {exec_error, device_error, query_error} = 3'b100 >> i;
      @(negedge clk);
    end
    {exec_error, device_error, query_error} = 3'b000;
    repeat (4) @(negedge clk);
    chk("event_summary", event_summary, 1'b1);
    cmd(CMD_ESR_Q, 8'h00);
    rd("28\n");
    repeat (2) @(negedge clk);
    chk("event_summary", event_summary, 1'b0);
    {slow, module_present, chan_load, chan_value} = 11'h507;
    @(negedge clk);
    chan_load = 1'b0;
    cmd(CMD_IDN_Q, 8'h00);
    rd("MFGX,CTRL,7,3-4\n");
    for (int i = 0; i < 4; i++) begin
      {local_switch_pin, ren_pin} = i[1:0];
      repeat (5) @(negedge clk);
      chk("remote_permit", remote_permit, i == 1);
    end
    // mid-run reset: power-on event bit, default mask and channel come back
    sys_rst = 1'b1;
    trim_supported = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset outputs", {cmd_ready, reply_valid, reply_data, event_summary, status_clear, remote_permit}, 13'h0000);
    sys_rst = 1'b0;
    cmd(CMD_ESR_Q, 8'h00);
    rd("128\n");
    cmd(CMD_ESE_Q, 8'h00);
    rd("0\n");
    cmd(CMD_IDN_Q, 8'h00);
    rd("MFGX,CTRL,1,3-4\n");
    cmd(CMD_OPT_Q, 8'h00);
    rd("RLS\n");
    end_sim;
  end
endmodule
`default_nettype wire

// >>> verilog/ccs_common_unit.sv
/*
  Common command and status unit: takes decoded common commands, keeps the
  standard event status and enable registers through its helper, answers
  the queries as ASCII bytes and defers operation complete.
  Assumes an upstream parser delivers one command code per accepted
  cmd_valid, that ops_busy is high while any earlier command or output
  level change is still in progress, and that the reply sink drains bytes
  with reply_ready.
*/
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Clear-status empties events; enable masks are kept
// - Enable mask takes 0..255, zero after reset
// - Summary bit is OR of enabled events
// - Fixed event bit layout, bits 6 and 1 unused
// - Enable query returns stored mask as integer
// - Event query returns register, then clears it
// - Identity reply: maker, model, serial, firmware
// - Serial field carries the selected channel number
// - Firmware field: controller and module revision, hyphenated
// - No module present gives controller-only model
// - After power-up channel one is reported
// - Completion bit set once all work finished
// - Completion command does not stall later commands
// - Completion query replies character one when done
// - Completion query holds off later commands
// - Options reply depends on trim support, switch fitted
// - Local mode with switch permits only measurements
// - Unknown command sets command error bit
// - Status byte query does not clear it
module ccs_common_unit
  import ccs_pkg::*;
#(
  parameter logic [31:0] MFG_NAME = "MFGX",
  parameter logic [31:0] MODEL_CTRL_ONLY = "CTRL",
  parameter logic [3:0][31:0] MODEL_TABLE = {"PWM3", "PWM2", "PWM1", "PWM0"},
  parameter logic [23:0] TRIM_TOKEN = "TRM",
  parameter logic [23:0] RLS_TOKEN = "RLS"
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // decoded command in
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic cmd_ready,
  // reply bytes to the output queue
  output logic reply_valid,
  output logic [7:0] reply_data,
  input wire logic reply_ready,
  // events and completion from the rest of the controller
  input wire logic exec_error,
  input wire logic device_error,
  input wire logic query_error,
  input wire logic ops_busy,
  // channel selection, module description and other status byte bits
  input wire logic chan_load,
  input wire logic [7:0] chan_value,
  input wire logic module_present,
  input wire logic [1:0] module_type,
  input wire logic [7:0] ctrl_rev,
  input wire logic [7:0] module_rev,
  input wire logic trim_supported,
  input wire logic rl_switch_fitted,
  input wire logic [7:0] stb_other,
  // pins
  input wire logic local_switch_pin,
  input wire logic ren_pin,
  // status outputs
  output logic event_summary,
  output logic status_clear,
  output logic remote_permit
);

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_ITEM, ST_DIGIT} ccs_state_e;

  ccs_esr_if esr_bus ();
  ccs_dec_if dec_bus ();

  ccs_state_e state_ff, nxt_state;
  ccs_cmd_e cmd_ff, nxt_cmd;
  ccs_cmd_e cmd_in;
  logic [4:0] idx_ff, nxt_idx;
  logic [1:0] dsel_ff, nxt_dsel;
  logic cmd_ready_ff;
  logic reply_valid_ff;
  logic [7:0] reply_data_ff;
  logic event_summary_ff;
  logic status_clear_ff;
  logic remote_permit_ff;
  logic opc_pend_ff;
  logic [7:0] snap_ff;
  logic [7:0] chan_ff;
  logic ren_meta_ff, ren_sync_ff;
  logic loc_meta_ff, loc_sync_ff;
  logic accept;
  logic slot_free;
  logic opc_done;
  logic load_en;
  logic [7:0] load_byte;
  logic [31:0] model_str;
  ccs_item_s item;

  function automatic logic [7:0] str_char(input logic [31:0] s, input logic [1:0] k);
    logic [7:0] c;
    case (k)
      2'd0: c = s[31:24];
      2'd1: c = s[23:16];
      2'd2: c = s[15:8];
      default: c = s[7:0];
    endcase
    return c;
  endfunction

  // reply script: one item per index for each query
  function automatic ccs_item_s get_item(input ccs_cmd_e cmd, input logic [4:0] idx, input logic [31:0] model,
                                         input logic trim, input logic rls);
    ccs_item_s it;
    it = '{op: OP_END, ch: CH_LF, num: NUM_SNAP};
    case (cmd)
      CMD_IDN_Q: begin
        case (idx)
          5'd0, 5'd1, 5'd2, 5'd3: it = '{op: OP_CHAR, ch: str_char(MFG_NAME, idx[1:0]), num: NUM_SNAP};
          5'd4, 5'd9, 5'd11: it = '{op: OP_CHAR, ch: CH_COMMA, num: NUM_SNAP};
          5'd5, 5'd6, 5'd7, 5'd8: it = '{op: OP_CHAR, ch: str_char(model, 2'(idx - 5'd5)), num: NUM_SNAP};
          5'd10: it = '{op: OP_NUM, ch: CH_LF, num: NUM_CHAN};
          5'd12: it = '{op: OP_NUM, ch: CH_LF, num: NUM_CREV};
          5'd13: it = '{op: OP_CHAR, ch: CH_HYPHEN, num: NUM_SNAP};
          5'd14: it = '{op: OP_NUM, ch: CH_LF, num: NUM_MREV};
          5'd15: it = '{op: OP_CHAR, ch: CH_LF, num: NUM_SNAP};
          default: it = '{op: OP_END, ch: CH_LF, num: NUM_SNAP};
        endcase
      end
      CMD_ESE_Q, CMD_ESR_Q, CMD_STB_Q: begin
        case (idx)
          5'd0: it = '{op: OP_NUM, ch: CH_LF, num: NUM_SNAP};
          5'd1: it = '{op: OP_CHAR, ch: CH_LF, num: NUM_SNAP};
          default: it = '{op: OP_END, ch: CH_LF, num: NUM_SNAP};
        endcase
      end
      CMD_OPC_Q: begin
        case (idx)
          5'd0: it = '{op: OP_CHAR, ch: CH_ONE, num: NUM_SNAP};
          5'd1: it = '{op: OP_CHAR, ch: CH_LF, num: NUM_SNAP};
          default: it = '{op: OP_END, ch: CH_LF, num: NUM_SNAP};
        endcase
      end
      CMD_OPT_Q: begin
        case (idx)
          5'd0, 5'd1, 5'd2: it = '{op: trim ? OP_CHAR : OP_SKIP, ch: str_char({TRIM_TOKEN, 8'h00}, idx[1:0]),
                                   num: NUM_SNAP};
          5'd3: it = '{op: (trim && rls) ? OP_CHAR : OP_SKIP, ch: CH_COMMA, num: NUM_SNAP};
          5'd4, 5'd5, 5'd6: it = '{op: rls ? OP_CHAR : OP_SKIP, ch: str_char({RLS_TOKEN, 8'h00}, 2'(idx - 5'd4)),
                                   num: NUM_SNAP};
          5'd7: it = '{op: OP_CHAR, ch: CH_LF, num: NUM_SNAP};
          default: it = '{op: OP_END, ch: CH_LF, num: NUM_SNAP};
        endcase
      end
      default: it = '{op: OP_END, ch: CH_LF, num: NUM_SNAP};
    endcase
    return it;
  endfunction

  assign cmd_in = (cmd_code <= 4'(CMD_UNKNOWN)) ? ccs_cmd_e'(cmd_code) : CMD_UNKNOWN;
  assign accept = cmd_valid && cmd_ready_ff;
  assign slot_free = !reply_valid_ff || reply_ready;
  assign model_str = module_present ? MODEL_TABLE[module_type] : MODEL_CTRL_ONLY;
  assign item = get_item(cmd_ff, idx_ff, model_str, trim_supported, rl_switch_fitted);
  assign opc_done = opc_pend_ff && !ops_busy;

  // event status helper
  always_comb begin
    esr_bus.set_bits = 8'h00;
    esr_bus.set_bits[EVT_CME_BIT] = accept && (cmd_in == CMD_UNKNOWN);
    esr_bus.set_bits[EVT_EXE_BIT] = exec_error;
    esr_bus.set_bits[EVT_DDE_BIT] = device_error;
    esr_bus.set_bits[EVT_QYE_BIT] = query_error;
    esr_bus.set_bits[EVT_OPC_BIT] = opc_done;
  end
  assign esr_bus.clear = accept && ((cmd_in == CMD_CLS) || (cmd_in == CMD_ESR_Q));
  assign esr_bus.mask_load = accept && (cmd_in == CMD_ESE);
  assign esr_bus.mask_val = cmd_arg;

  ccs_event_status u_event_status (
    .clk(clk),
    .sys_rst(sys_rst),
    .standard_event_status(esr_bus)
  );

  ccs_decimal u_decimal (
    .clk(clk),
    .sys_rst(sys_rst),
    .dec(dec_bus)
  );

  assign dec_bus.sel = dsel_ff;
  assign dec_bus.start = (state_ff == ST_ITEM) && slot_free && (item.op == OP_NUM);
  always_comb begin
    case (item.num)
      NUM_CHAN: dec_bus.value = chan_ff;
      NUM_CREV: dec_bus.value = ctrl_rev;
      NUM_MREV: dec_bus.value = module_rev;
      default: dec_bus.value = snap_ff;
    endcase
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_idx = idx_ff;
    nxt_dsel = dsel_ff;
    load_en = 1'b0;
    load_byte = CH_LF;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          case (cmd_in)
            CMD_ESE_Q, CMD_ESR_Q, CMD_STB_Q, CMD_IDN_Q, CMD_OPT_Q: begin
              nxt_state = ST_ITEM;
              nxt_cmd = cmd_in;
              nxt_idx = 5'd0;
            end
            CMD_OPC_Q: begin
              nxt_state = ST_HOLD;
              nxt_cmd = cmd_in;
              nxt_idx = 5'd0;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_HOLD: begin
        if (!ops_busy) begin
          nxt_state = ST_ITEM;
        end
      end
      ST_ITEM: begin
        if (slot_free) begin
          case (item.op)
            OP_CHAR: begin
              load_en = 1'b1;
              load_byte = item.ch;
              nxt_idx = idx_ff + 5'd1;
            end
            OP_SKIP: nxt_idx = idx_ff + 5'd1;
            OP_NUM: begin
              nxt_state = ST_DIGIT;
              nxt_dsel = 2'd0;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      default: begin
        if (slot_free) begin
          load_en = 1'b1;
          load_byte = dec_bus.digit;
          if (dec_bus.last) begin
            nxt_idx = idx_ff + 5'd1;
            nxt_state = ST_ITEM;
          end else begin
            nxt_dsel = dsel_ff + 2'd1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cmd_ff <= CMD_UNKNOWN;
      idx_ff <= 5'd0;
      dsel_ff <= 2'd0;
      cmd_ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      idx_ff <= nxt_idx;
      dsel_ff <= nxt_dsel;
      cmd_ready_ff <= (nxt_state == ST_IDLE);
    end
  end

  // reply byte slot
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reply_valid_ff <= 1'b0;
      reply_data_ff <= 8'h00;
    end else if (load_en) begin
      reply_valid_ff <= 1'b1;
      reply_data_ff <= load_byte;
    end else if (reply_ready) begin
      reply_valid_ff <= 1'b0;
    end
  end

  // query value snapshot; the status byte read leaves its sources alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_ff <= 8'h00;
    end else if (accept) begin
      case (cmd_in)
        CMD_ESE_Q: snap_ff <= esr_bus.mask;
        CMD_ESR_Q: snap_ff <= esr_bus.status;
        CMD_STB_Q: begin
          snap_ff <= stb_other;
          snap_ff[STB_ESB_BIT] <= esr_bus.summary;
        end
        default: snap_ff <= snap_ff;
      endcase
    end
  end

  // a new completion command wins over the finishing one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opc_pend_ff <= 1'b0;
    end else if (accept && (cmd_in == CMD_OPC)) begin
      opc_pend_ff <= 1'b1;
    end else if (opc_done) begin
      opc_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_ff <= POWERUP_CHANNEL;
    end else if (chan_load) begin
      chan_ff <= chan_value;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_summary_ff <= 1'b0;
      status_clear_ff <= 1'b0;
    end else begin
      event_summary_ff <= esr_bus.summary;
      status_clear_ff <= accept && (cmd_in == CMD_CLS);
    end
  end

  // pin synchronisers and remote gating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ren_meta_ff <= 1'b0;
      ren_sync_ff <= 1'b0;
      loc_meta_ff <= 1'b0;
      loc_sync_ff <= 1'b0;
      remote_permit_ff <= 1'b0;
    end else begin
      ren_meta_ff <= ren_pin;
      ren_sync_ff <= ren_meta_ff;
      loc_meta_ff <= local_switch_pin;
      loc_sync_ff <= loc_meta_ff;
      remote_permit_ff <= !rl_switch_fitted || (ren_sync_ff && !loc_sync_ff);
    end
  end

  assign cmd_ready = cmd_ready_ff;
  assign reply_valid = reply_valid_ff;
  assign reply_data = reply_data_ff;
  assign event_summary = event_summary_ff;
  assign status_clear = status_clear_ff;
  assign remote_permit = remote_permit_ff;

  chk_cls_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    accept && (cmd_in == CMD_CLS) |=> status_clear_ff && $stable(esr_bus.mask))
    else $error("clear status missed pulse or touched mask");

  chk_mask_store: assert property (@(posedge clk) disable iff (sys_rst)
    accept && (cmd_in == CMD_ESE) |=> esr_bus.mask == $past(cmd_arg))
    else $error("enable mask not stored");

  chk_summary_bit: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> event_summary_ff == |($past(esr_bus.status) & $past(esr_bus.mask)))
    else $error("summary bit wrong");

  chk_unknown_cme: assert property (@(posedge clk) disable iff (sys_rst)
    accept && (cmd_in == CMD_UNKNOWN) |=> esr_bus.status[EVT_CME_BIT])
    else $error("unknown command did not flag command error");

  chk_esr_readback: assert property (@(posedge clk) disable iff (sys_rst)
    accept && (cmd_in == CMD_ESR_Q) |=> (snap_ff == $past(esr_bus.status)) && (state_ff == ST_ITEM))
    else $error("event query snapshot wrong");

  chk_opc_deferred: assert property (@(posedge clk) disable iff (sys_rst)
    ops_busy && !esr_bus.status[EVT_OPC_BIT] |=> !esr_bus.status[EVT_OPC_BIT])
    else $error("completion bit set while busy");

  chk_opc_nostall: assert property (@(posedge clk) disable iff (sys_rst)
    accept && (cmd_in == CMD_OPC) && (state_ff == ST_IDLE) |=> cmd_ready_ff)
    else $error("completion command stalled commands");

  chk_opcq_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == ST_HOLD) && ops_busy |=> !cmd_ready_ff && (state_ff == ST_HOLD))
    else $error("completion query did not hold off");

  chk_opcq_one: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == ST_ITEM) && (cmd_ff == CMD_OPC_Q) && (idx_ff == 5'd0) && slot_free
    |=> reply_valid_ff && (reply_data_ff == CH_ONE))
    else $error("completion query did not queue one");

  chk_local_gate: assert property (@(posedge clk) disable iff (sys_rst)
    rl_switch_fitted && loc_sync_ff |=> !remote_permit_ff)
    else $error("remote functions permitted in local mode");

  chk_reply_stands: assert property (@(posedge clk) disable iff (sys_rst)
    reply_valid_ff && !reply_ready |=> reply_valid_ff && $stable(reply_data_ff))
    else $error("reply byte changed before taken");

endmodule
`default_nettype wire

// >>> verilog/ccs_decimal.sv
/*
  Turns an 8-bit value into up to three ASCII decimal digits, most
  significant first, with no leading zeros.
  Assumes start is a one-cycle strobe and sel is only stepped afterwards.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_decimal
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // controller side
  ccs_dec_if.unit dec
);

  logic [3:0] dig_ff [4];
  logic [1:0] ndig_ff;
  logic [7:0] hund;
  logic [7:0] tens;
  logic [7:0] ones;

  always_comb begin
    hund = dec.value / 8'd100;
    tens = (dec.value / 8'd10) % 8'd10;
    ones = dec.value % 8'd10;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dig_ff <= '{4'h0, 4'h0, 4'h0, 4'h0};
      ndig_ff <= 2'd1;
    end else if (dec.start) begin
      if (hund != 8'h00) begin
        dig_ff <= '{hund[3:0], tens[3:0], ones[3:0], 4'h0};
        ndig_ff <= 2'd3;
      end else if (tens != 8'h00) begin
        dig_ff <= '{tens[3:0], ones[3:0], 4'h0, 4'h0};
        ndig_ff <= 2'd2;
      end else begin
        dig_ff <= '{ones[3:0], 4'h0, 4'h0, 4'h0};
        ndig_ff <= 2'd1;
      end
    end
  end

  assign dec.digit = CH_ZERO | {4'h0, dig_ff[dec.sel]};
  assign dec.last = (dec.sel == (ndig_ff - 2'd1));

endmodule
`default_nettype wire

// >>> verilog/ccs_event_status.sv
/*
  Standard event status register, its enable mask and the summary bit.
  Assumes set, clear and mask load come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_event_status
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // controller side
  ccs_esr_if.unit standard_event_status
);

  logic [7:0] status_ff;
  logic [7:0] mask_ff;

  // set beats clear, so an event in the clearing cycle survives
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_ff <= ESR_RESET;
    end else begin
      status_ff <= (standard_event_status.clear ? 8'h00 : status_ff) | (standard_event_status.set_bits & EVT_USED_MASK);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_ff <= ESE_RESET;
    end else if (standard_event_status.mask_load) begin
      mask_ff <= standard_event_status.mask_val;
    end
  end

  assign standard_event_status.status = status_ff;
  assign standard_event_status.mask = mask_ff;
  assign standard_event_status.summary = |(status_ff & mask_ff);

  chk_sticky_bits: assert property (@(posedge clk) disable iff (sys_rst)
    !standard_event_status.clear |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
    else $error("event status bit dropped without clear");

  chk_clear_empties: assert property (@(posedge clk) disable iff (sys_rst)
    standard_event_status.clear && (standard_event_status.set_bits == 8'h00) |=> status_ff == 8'h00)
    else $error("event status not emptied by clear");

  chk_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (status_ff[6] == 1'b0) && (status_ff[1] == 1'b0))
    else $error("unused event bit was set");

endmodule
`default_nettype wire

// >>> verilog/ccs_if.sv
/*
  Carriers between the controller and its two helpers: the event status
  unit and the decimal digit unit.
  Assumes all ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface ccs_esr_if;
  logic [7:0] set_bits;
  logic clear;
  logic mask_load;
  logic [7:0] mask_val;
  logic [7:0] status;
  logic [7:0] mask;
  logic summary;
  modport ctrl (output set_bits, clear, mask_load, mask_val, input status, mask, summary);
  modport unit (input set_bits, clear, mask_load, mask_val, output status, mask, summary);
endinterface

interface ccs_dec_if;
  logic start;
  logic [7:0] value;
  logic [1:0] sel;
  logic [7:0] digit;
  logic last;
  modport ctrl (output start, value, sel, input digit, last);
  modport unit (input start, value, sel, output digit, last);
endinterface
`default_nettype wire

// >>> verilog/ccs_pkg.sv
/*
  Shared constants and types for the common command and status unit:
  event status bit positions, reset values, reply characters, command codes
  and the reply item encoding.
  Assumes a single 100 MHz clock domain and an upstream parser that has
  already turned the command text into one command code.
*/
`default_nettype none
package ccs_pkg;

  // event status and enable bit positions
  localparam int EVT_PON_BIT = 7;
  localparam int EVT_CME_BIT = 5;
  localparam int EVT_EXE_BIT = 4;
  localparam int EVT_DDE_BIT = 3;
  localparam int EVT_QYE_BIT = 2;
  localparam int EVT_OPC_BIT = 0;
  localparam logic [7:0] EVT_USED_MASK = 8'hbd;

  // status byte bit carrying the event summary
  localparam int STB_ESB_BIT = 5;

  // values after reset
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] POWERUP_CHANNEL = 8'h01;

  // reply characters
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_HYPHEN = 8'h2d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_LF = 8'h0a;

  typedef enum logic [3:0] {
    CMD_CLS, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_IDN_Q,
    CMD_OPC, CMD_OPC_Q, CMD_OPT_Q, CMD_STB_Q, CMD_UNKNOWN
  } ccs_cmd_e;

  typedef enum logic [1:0] {OP_CHAR, OP_NUM, OP_SKIP, OP_END} ccs_op_e;
  typedef enum logic [1:0] {NUM_SNAP, NUM_CHAN, NUM_CREV, NUM_MREV} ccs_num_e;

  typedef struct packed {
    ccs_op_e op;
    logic [7:0] ch;
    ccs_num_e num;
  } ccs_item_s;

endpackage
`default_nettype wire
